// [inc/pisf_flag_if.sv]
`default_nettype none
interface pisf_flag_if #(parameter int W = 6);
    logic [W-1:0] set;
    logic [W-1:0] live;
    logic [W-1:0] clr;
    logic [W-1:0] mask;
    logic [W-1:0] value;
    logic [W-1:0] pend;
    modport bank (input set, input live, input clr, input mask,
        output value, output pend);
    modport user (output set, output live, output clr, output mask,
        input value, input pend);
endinterface
`default_nettype wire

// [inc/pisf_pkg.sv]
// Summary of operation
// RULE1 - status one at sub-address 1, read-only, resets zero, bits 7:6 read 0
// RULE2 - bit 5 of status one sets when supply is too low to program defaults
// RULE3 - bit 4 of status one sets on any mains-detect pin level change
// RULE4 - bit 3 of status one sets on any push-button level change
// RULE5 - bit 2 of status one follows the thermal early-warning level
// RULE6 - bit 1 of status one sets when backup-cell comparators have settled
// RULE7 - bit 0 of status one sets when default-setting programming completed
// RULE8 - status two at sub-address 2, read-only, resets zero, 7:6 reserved
// RULE9 - bits 5 and 3 of status two set on switch three/one thermal fault
// RULE10 - bit 4 of status two sets on switch two thermal or low-input fault
// RULE11 - status two bits 2:0 follow limiting of switches three, two, one
// RULE12 - gate bit zero lets a flag pull the line low; one blocks it
// RULE13 - gate bits never stop flags from updating
// RULE14 - flags held until read; line released when no unmasked flag remains
`default_nettype none
package pisf_pkg;
    localparam int REG_W = 8;
    localparam int FLAG_W = 6;
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h01;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h02;
    localparam logic [7:0] ADDR_GATE_ONE = 8'h03;
    localparam logic [7:0] ADDR_GATE_TWO = 8'h04;
    localparam logic [7:0] RESET_REG = 8'h00;
    localparam logic [5:0] RESET_FLAGS = 6'h00;
    localparam logic [1:0] RESERVED_VAL = 2'h0;
    // status one field positions
    localparam int B_LOW_SUPPLY = 5;
    localparam int B_MAINS = 4;
    localparam int B_BUTTON = 3;
    localparam int B_THERMAL = 2;
    localparam int B_MEASURE = 1;
    localparam int B_PROGRAM = 0;
    // status two field positions
    localparam int B_SW3_FAULT = 5;
    localparam int B_SW2_FAULT = 4;
    localparam int B_SW1_FAULT = 3;
    localparam int B_SW3_LIMIT = 2;
    localparam int B_SW2_LIMIT = 1;
    localparam int B_SW1_LIMIT = 0;
    // bits that show a live level rather than a held event
    localparam logic [7:0] LEVEL_ONE = 8'h04;
    localparam logic [7:0] LEVEL_TWO = 8'h07;
endpackage
`default_nettype wire

// [tb/pisf_host.sv]
`default_nettype none
module pisf_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // released lines carry the inverse so a stale value is never trusted
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int n;
        n = 0;
        v = 'x;
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk);
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (reg_rvalid === 1'b1)
            v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [tb/pisf_top_bench.sv]
`default_nettype none
module pisf_top_bench
    import pisf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [11:0] stim;
        logic [7:0] addr;
        logic [7:0] exp;
    } pisf_row_t;
    logic clk, rstn, mains_detect_pin, button_pin, low_supply_evt;
    logic thermal_warn, measure_done_evt, program_done_evt;
    logic reg_rd, reg_wr, reg_rvalid, irq_line_n;
    logic [2:0] switch_fault_evt, switch_limit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    int miscompares, num_checks;
    // stim: 0 prog, 1 measure, 2 thermal, 3 button, 4 mains, 5 low supply,
    // 8:6 switch faults, 11:9 switch limits
    pisf_row_t rows [10] = '{
        '{12'h001, 8'h01, 8'h01}, '{12'h002, 8'h01, 8'h02},
        '{12'h004, 8'h01, 8'h04}, '{12'h008, 8'h01, 8'h08},
        '{12'h010, 8'h01, 8'h10}, '{12'h020, 8'h01, 8'h20},
        '{12'h100, 8'h02, 8'h20}, '{12'h080, 8'h02, 8'h10},
        '{12'h040, 8'h02, 8'h08}, '{12'hE00, 8'h02, 8'h07}};
    pisf_top pisf_top_inst (.clk(clk), .rstn(rstn),
        .mains_detect_pin(mains_detect_pin), .button_pin(button_pin),
        .low_supply_evt(low_supply_evt), .thermal_warn(thermal_warn),
        .measure_done_evt(measure_done_evt),
        .program_done_evt(program_done_evt),
        .switch_fault_evt(switch_fault_evt), .switch_limit(switch_limit),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .irq_line_n(irq_line_n));
    pisf_host pisf_host_inst (.clk(clk), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    // -------------------------------------------------------------
    // checking helpers
    // -------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        pisf_host_inst.rd(a, d);
        chk(d, e);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // pulses drop after one edge, levels stay until the next apply
    task automatic apply(input logic [11:0] s);
        @(posedge clk);
        program_done_evt <= s[0];
        measure_done_evt <= s[1];
        thermal_warn <= s[2];
        button_pin <= button_pin ^ s[3];
        mains_detect_pin <= mains_detect_pin ^ s[4];
        low_supply_evt <= s[5];
        switch_fault_evt <= s[8:6];
        switch_limit <= s[11:9];
        @(posedge clk);
        program_done_evt <= 1'b0;
        measure_done_evt <= 1'b0;
        low_supply_evt <= 1'b0;
        switch_fault_evt <= 3'h0;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        {rstn, mains_detect_pin, button_pin, low_supply_evt} = 4'h0;
        {thermal_warn, measure_done_evt, program_done_evt} = 3'h0;
        switch_fault_evt = 3'h0;
        switch_limit = 3'h0;
        miscompares = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rc(8'h01, RESET_REG);
        rc(8'h02, RESET_REG);
        rc(8'h05, 8'h00);
        chk({7'h0, irq_line_n}, 8'h01);
        pisf_host_inst.wr(8'h01, 8'hFF);
        pisf_host_inst.wr(8'h02, 8'hFF);
        rc(8'h01, 8'h00);
        rc(8'h02, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            apply(rows[i].stim);
            rc(rows[i].addr, rows[i].exp);
            chk({7'h0, irq_line_n}, 8'h00);
            apply(12'h000);
            pisf_host_inst.rd(8'h01, d);
            pisf_host_inst.rd(8'h02, d);
            repeat (3) @(negedge clk);
            chk({7'h0, irq_line_n}, 8'h01);
            rc(8'h01, 8'h00);
            rc(8'h02, 8'h00);
            $display("test row %0d done", i);
        end
        pisf_host_inst.wr(8'h03, 8'hFF);
        rc(8'h03, 8'h3F);
        pisf_host_inst.wr(8'h04, 8'hFF);
        rc(8'h04, 8'h3F);
        apply(12'h001);
        repeat (3) @(negedge clk);
        chk({7'h0, irq_line_n}, 8'h01);
        rc(8'h01, 8'h01);
        apply(12'h040);
        repeat (3) @(negedge clk);
        chk({7'h0, irq_line_n}, 8'h01);
        rc(8'h02, 8'h08);
        pisf_host_inst.wr(8'h03, 8'h00);
        $display("test gate done");
        // an event landing on the read edge must survive the clear
        fork
            pisf_host_inst.rd(8'h01, d);
            begin
                @(posedge clk);
                program_done_evt <= 1'b1;
                @(posedge clk);
                program_done_evt <= 1'b0;
            end
        join
        chk(d, 8'h00);
        rc(8'h01, 8'h01);
        rc(8'h01, 8'h00);
        $display("test set wins done");
        apply(12'h002);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rc(8'h01, RESET_REG);
        rc(8'h04, RESET_REG);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// [verilog/pisf_flag_bank.sv]
`default_nettype none
module pisf_flag_bank
    import pisf_pkg::*;
#(
    parameter int W = 6,
    parameter logic [7:0] LEVEL = 8'h00
) (
    input wire logic clk,
    input wire logic rstn,
    pisf_flag_if.bank fi
);
    typedef struct packed {
        logic [W-1:0] sticky;
    } pisf_bank_t;

    pisf_bank_t st;
    pisf_bank_t next_st;
    logic [W-1:0] lvl;
    logic [W-1:0] set_ev;

    // a bank wider than one register could not be read back whole
    if (W < 1 || W > REG_W) begin : g_bad_width
        $error("flag bank width must be 1 to 8");
    end

    assign lvl = LEVEL[W-1:0];
    assign set_ev = fi.set & ~lvl;

    // a set arriving with the read clear wins, so no event is lost
    always_comb begin
        next_st = st;
        next_st.sticky = ((st.sticky & ~fi.clr) | set_ev) & ~lvl; // [RULE14]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // gate only reaches the line, never the stored flag
    assign fi.value = st.sticky | (fi.live & lvl); // [RULE13]
    assign fi.pend = fi.value & ~fi.mask; // [RULE12]

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    set_wins_a: assert property ( // [RULE14]
        (set_ev != '0) |=> ((st.sticky & $past(set_ev)) == $past(set_ev)))
        else $error("event lost against a clear");
    hold_until_clr_a: assert property ( // [RULE14]
        ((fi.clr & st.sticky) == '0) |=>
        ((st.sticky & $past(st.sticky)) == $past(st.sticky)))
        else $error("held flag dropped without a read");
endmodule
`default_nettype wire

// [verilog/pisf_top.sv]
`default_nettype none
module pisf_top
    import pisf_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic mains_detect_pin,
    input wire logic button_pin,
    input wire logic low_supply_evt,
    input wire logic thermal_warn,
    input wire logic measure_done_evt,
    input wire logic program_done_evt,
    input wire logic [2:0] switch_fault_evt,
    input wire logic [2:0] switch_limit,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic irq_line_n
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [FLAG_W-1:0] gate_one;
        logic [FLAG_W-1:0] gate_two;
        logic prev_mains;
        logic prev_button;
        logic primed;
        logic [REG_W-1:0] rdata;
        logic rvalid;
        logic irq_n;
    } pisf_top_t;

    pisf_top_t st;
    pisf_top_t next_st;

    pisf_flag_if #(.W(FLAG_W)) f1 ();
    pisf_flag_if #(.W(FLAG_W)) f2 ();

    // reserved upper bits always read zero
    function automatic logic [REG_W-1:0] fld8(input logic [FLAG_W-1:0] v);
        fld8 = {RESERVED_VAL, v};
    endfunction

    logic rd_one;
    logic rd_two;
    logic mains_chg;
    logic button_chg;

    assign rd_one = reg_rd && (reg_addr == ADDR_STATUS_ONE);
    assign rd_two = reg_rd && (reg_addr == ADDR_STATUS_TWO);
    // no edge is reported until the first pin level has been seen
    assign mains_chg = st.primed && (mains_detect_pin != st.prev_mains);
    assign button_chg = st.primed && (button_pin != st.prev_button);

    // ----------------------------------------------------------------
    // flag sources
    // ----------------------------------------------------------------
    always_comb begin
        f1.set = '0;
        f1.set[B_LOW_SUPPLY] = low_supply_evt; // [RULE2]
        f1.set[B_MAINS] = mains_chg; // [RULE3]
        f1.set[B_BUTTON] = button_chg; // [RULE4]
        f1.set[B_MEASURE] = measure_done_evt; // [RULE6]
        f1.set[B_PROGRAM] = program_done_evt; // [RULE7]
        f1.live = '0;
        f1.live[B_THERMAL] = thermal_warn; // [RULE5]
        f2.set = '0;
        f2.set[B_SW3_FAULT] = switch_fault_evt[2]; // [RULE9]
        f2.set[B_SW2_FAULT] = switch_fault_evt[1]; // [RULE10]
        f2.set[B_SW1_FAULT] = switch_fault_evt[0]; // [RULE9]
        f2.live = '0;
        f2.live[B_SW3_LIMIT] = switch_limit[2]; // [RULE11]
        f2.live[B_SW2_LIMIT] = switch_limit[1]; // [RULE11]
        f2.live[B_SW1_LIMIT] = switch_limit[0]; // [RULE11]
    end

    // a read clears exactly what it returned
    assign f1.clr = rd_one ? f1.value : '0; // [RULE14]
    assign f2.clr = rd_two ? f2.value : '0; // [RULE14]
    assign f1.mask = st.gate_one;
    assign f2.mask = st.gate_two;

    pisf_flag_bank #(.W(FLAG_W), .LEVEL(LEVEL_ONE)) u_bank_one (
        .clk(clk),
        .rstn(rstn),
        .fi(f1)
    );

    pisf_flag_bank #(.W(FLAG_W), .LEVEL(LEVEL_TWO)) u_bank_two (
        .clk(clk),
        .rstn(rstn),
        .fi(f2)
    );

    // ----------------------------------------------------------------
    // register port and interrupt line
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.prev_mains = mains_detect_pin;
        next_st.prev_button = button_pin;
        next_st.primed = 1'b1;
        next_st.rvalid = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_STATUS_ONE: next_st.rdata = fld8(f1.value); // [RULE1]
                ADDR_STATUS_TWO: next_st.rdata = fld8(f2.value); // [RULE8]
                ADDR_GATE_ONE: next_st.rdata = fld8(st.gate_one);
                ADDR_GATE_TWO: next_st.rdata = fld8(st.gate_two);
                default: next_st.rdata = RESET_REG;
            endcase
        end
        // status registers are read-only, writes there are dropped
        if (reg_wr && (reg_addr == ADDR_GATE_ONE)) begin
            next_st.gate_one = reg_wdata[FLAG_W-1:0];
        end
        if (reg_wr && (reg_addr == ADDR_GATE_TWO)) begin
            next_st.gate_two = reg_wdata[FLAG_W-1:0];
        end
        // line follows flags one cycle late; released when none unmasked
        next_st.irq_n = !((|f1.pend) || (|f2.pend)); // [RULE12] [RULE14]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st.gate_one <= RESET_FLAGS;
            st.gate_two <= RESET_FLAGS;
            st.prev_mains <= 1'b0;
            st.prev_button <= 1'b0;
            st.primed <= 1'b0;
            st.rdata <= RESET_REG;
            st.rvalid <= 1'b0;
            st.irq_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign irq_line_n = st.irq_n;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence read_one_s;
        reg_rd && (reg_addr == ADDR_STATUS_ONE);
    endsequence

    sequence read_two_s;
        reg_rd && (reg_addr == ADDR_STATUS_TWO);
    endsequence

    sequence answer_s;
        reg_rvalid;
    endsequence

    reserved_zero_a: assert property ( // [RULE1] [RULE8]
        (read_one_s or read_two_s) |=> answer_s ##0
        (reg_rdata[7:6] == RESERVED_VAL))
        else $error("reserved status bits not zero");

    mains_edge_a: assert property ( // [RULE3]
        (st.primed && $changed(mains_detect_pin)) |=> f1.value[B_MAINS])
        else $error("mains-detect change not flagged");

    button_edge_a: assert property ( // [RULE4]
        (st.primed && $changed(button_pin)) |=> f1.value[B_BUTTON])
        else $error("button change not flagged");

    low_supply_a: assert property ( // [RULE2]
        low_supply_evt |=> f1.value[B_LOW_SUPPLY])
        else $error("low supply flag not set");

    done_flags_a: assert property ( // [RULE6] [RULE7]
        (measure_done_evt || program_done_evt) |=>
        ((f1.value[B_MEASURE] || !$past(measure_done_evt)) &&
        (f1.value[B_PROGRAM] || !$past(program_done_evt))))
        else $error("completion flags not set");

    thermal_live_a: assert property ( // [RULE5]
        read_one_s |=> (reg_rdata[B_THERMAL] == $past(thermal_warn)))
        else $error("thermal bit not live");

    limit_live_a: assert property ( // [RULE11]
        read_two_s |=> (reg_rdata[2:0] == $past(switch_limit)))
        else $error("limit bits not live");

    fault_set_a: assert property ( // [RULE9] [RULE10]
        (switch_fault_evt != 3'h0) |=>
        ((f2.value[5:3] & $past(switch_fault_evt)) ==
        $past(switch_fault_evt)))
        else $error("switch fault not flagged");

    gate_monitor_a: assert property ( // [RULE13]
        (st.gate_one[B_PROGRAM] && program_done_evt) |=>
        f1.value[B_PROGRAM])
        else $error("gated flag not updated");

    irq_assert_a: assert property ( // [RULE12]
        ((|f1.pend) || (|f2.pend)) |=> !irq_line_n)
        else $error("unmasked flag did not pull line low");

    irq_release_a: assert property ( // [RULE12] [RULE14]
        (f1.pend == '0 && f2.pend == '0) |=> irq_line_n)
        else $error("line low with no unmasked flag");

    clear_read_a: assert property ( // [RULE14]
        (read_one_s ##0 (f1.set == '0)) |=>
        ((f1.value & ~LEVEL_ONE[FLAG_W-1:0]) == '0))
        else $error("read did not clear held flags");
endmodule
`default_nettype wire
